// ==== mpc_defines.svh ====
// Register offsets, field positions and timing counts of the program controller
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_TADDR 12'h008
`define OFF_CHAR 12'h00C
`define CTRL_START 4
`define CTRL_EXT 3
`define CTRL_UNLOCK 5
`define CTRL_STOP 6
`define CHAR_MOD 16
`define LIB_SIZE 1600
`define CLK_MHZ 200
`define TAPE_GAP_MS 200
`define TAPE_GAP_CYC (`TAPE_GAP_MS * 1000 * `CLK_MHZ)
`define PW_NEXT_LO 0
`define PW_NEXT_HI 1
`define PW_BR_LO 2
`define PW_BR_HI 3
`define PW_ACT 4
`define ACT_HALT_HI 0
`define ACT_HALT_LO 1
`define ACT_BR_HI 2
`define ACT_BR_LO 3
`define ACT_REPEAT 4
`define ACT_LAST 5
`endif

// ==== mpc_pkg.sv ====
// Types shared by the program controller
package mpc_pkg;
    typedef enum logic [2:0] {
        M_DISC_TAPE = 3'b000,
        M_LOCATE = 3'b001,
        M_DISC_SINGLE = 3'b010,
        M_DISC_SEQ = 3'b011,
        M_TAPE_SEQ = 3'b100,
        M_EXAMINE = 3'b101,
        M_REG_DISC = 3'b110,
        M_TAPE_DISC = 3'b111
    } mode_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LOAD = 3'b001,
        S_PUNCH = 3'b010,
        S_PDONE = 3'b011,
        S_MEAS = 3'b100,
        S_WRITE = 3'b101,
        S_GAP = 3'b110
    } state_t;
endpackage

// ==== measurement_program_controller.sv ====
// Measurement program controller: APB registers, program word and function sequencer
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// (R1) Eight modes, run only after start
// (R2) Fixed-length program word drives instruments
// (R3) Disc-to-tape: fill from disc, shift to punch
// (R4) Disc-to-tape: ready after punch done
// (R5) Locate: seek next address after measurement
// (R6) Single disc test: load, measure, ready
// (R7) Disc sequence: reload next address on done
// (R8) Disc sequence: branch or halt on limits
// (R9) Above and below limit act differently
// (R10) Repeat out-of-limit measurement before acting
// (R11) Tape sequence: measure until stop signal
// (R12) Tape sequence: halt on out-of-limit
// (R13) Examine: show selected character
// (R14) Modify: replace selected character
// (R15) Disc write blocked unless interlock released
// (R16) Tape-to-disc: fill from tape, write disc
// (R17) Disc library of 1600 programs
// (R18) Disc measurements above 100 per second
// (R19) Tape measurements at most 5 per second
// (R20) External source replaces disc and tape
// (R21) Selector sampled at start only
// (R22) Ready only when idle
// ----------------------------------------------------------------
`include "mpc_defines.svh"

module measurement_program_controller
    import mpc_pkg::*;
#(
    parameter int NCHAR = 16,
    parameter int unsigned TAPE_GAP = `TAPE_GAP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_ext,
    input wire logic disc_tgl,
    input wire logic [7:0] disc_data,
    input wire logic tape_tgl,
    input wire logic [7:0] tape_data,
    input wire logic ext_tgl,
    input wire logic [7:0] ext_data,
    input wire logic out_ack_tgl,
    input wire logic punch_done_tgl,
    input wire logic meas_done_tgl,
    input wire logic limit_hi,
    input wire logic limit_lo,
    input wire logic stop_in,
    output logic ready,
    output logic disc_seek,
    output logic disc_read,
    output logic [10:0] disc_addr,
    output logic meas_req,
    output logic punch_tgl,
    output logic disc_wr_tgl,
    output logic [7:0] out_data,
    output logic [7:0] char_display,
    output logic [NCHAR*8-1:0] prog_word
);
    localparam int CW = $clog2(NCHAR);
    localparam int SW = 34;
    localparam logic [CW-1:0] LASTC = CW'(NCHAR - 1);
    localparam logic [10:0] LIB = 11'(`LIB_SIZE);
    localparam logic [25:0] GAP_LD = 26'(TAPE_GAP - 1);

    typedef struct packed {
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic [6:0] sync3;
        state_t st;
        mode_t mode_run;
        mode_t mode_sel;
        logic ext_src;
        logic unlock;
        logic stop;
        logic [10:0] taddr;
        logic [CW-1:0] char_sel;
        logic [7:0] new_data;
        logic [NCHAR-1:0][7:0] prog;
        logic [CW-1:0] cnt;
        logic pend;
        logic retried;
        logic halted;
        logic refused;
        logic [25:0] gap;
        logic ready;
        logic disc_seek;
        logic disc_read;
        logic [10:0] disc_addr;
        logic meas_req;
        logic punch_tgl;
        logic wr_tgl;
        logic [7:0] out_data;
        logic [7:0] display;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ctl_t;

    ctl_t r_reg;
    ctl_t r_next;

    // Out-of-library addresses fold to zero so the disc never sees them
    function automatic logic [10:0] prog_addr(input logic [7:0] lo, input logic [7:0] hi);
        logic [10:0] a;
        a = {hi[2:0], lo};
        return (a < LIB) ? a : 11'h000;
    endfunction

    // ----------------------------------------------------------------
    // Pin events
    // ----------------------------------------------------------------
    logic [SW-1:0] pins;
    logic [6:0] ev;
    logic start_ev;
    logic from_tape;
    logic in_ev;
    logic [7:0] in_char;
    logic [7:0] act;
    logic hi;
    logic lo;
    logic oob;
    logic halt_hit;
    logic br_hit;
    logic stop_req;
    logic [10:0] next_a;
    logic [10:0] br_a;
    logic wr;
    logic start;
    logic mod_ev;
    logic [CW-1:0] mod_idx;
    logic [7:0] mod_dat;
    logic meas_ev;

    assign pins = {ext_data, tape_data, disc_data, stop_in, limit_lo, limit_hi,
                   meas_done_tgl, punch_done_tgl, out_ack_tgl, ext_tgl, tape_tgl,
                   disc_tgl, start_ext};
    // Sources flip a toggle per event, so no ack path is needed
    assign ev = r_reg.sync2[6:0] ^ r_reg.sync3;
    assign start_ev = r_reg.sync2[0] & ~r_reg.sync3[0];
    assign from_tape = (r_reg.mode_run == M_TAPE_SEQ) || (r_reg.mode_run == M_TAPE_DISC);
    // External data takes over when the ext bit of the control register is set  [R20]
    assign in_ev = r_reg.ext_src ? ev[3] : (from_tape ? ev[2] : ev[1]);
    assign in_char = r_reg.ext_src ? r_reg.sync2[33:26]
                   : (from_tape ? r_reg.sync2[25:18] : r_reg.sync2[17:10]);
    assign act = r_reg.prog[`PW_ACT];
    assign hi = r_reg.sync2[7];
    assign lo = r_reg.sync2[8];
    assign oob = hi | lo;
    assign halt_hit = (hi & act[`ACT_HALT_HI]) | (lo & act[`ACT_HALT_LO]); // [R9]
    assign br_hit = (hi & act[`ACT_BR_HI]) | (lo & act[`ACT_BR_LO]); // [R9]
    assign stop_req = r_reg.sync2[9] | r_reg.stop;
    assign next_a = prog_addr(r_reg.prog[`PW_NEXT_LO], r_reg.prog[`PW_NEXT_HI]);
    assign br_a = prog_addr(r_reg.prog[`PW_BR_LO], r_reg.prog[`PW_BR_HI]);
    assign wr = psel & penable & r_reg.pready & pwrite & ~r_reg.pslverr;
    assign start = (r_reg.st == S_IDLE)
                 & (start_ev | (wr & (paddr == `OFF_CTRL) & pwdata[`CTRL_START])); // [R1]
    assign mod_ev = wr & (paddr == `OFF_CHAR) & pwdata[`CHAR_MOD]
                  & (r_reg.st == S_IDLE) & (r_reg.mode_sel == M_EXAMINE);
    assign mod_idx = pwdata[CW-1:0];
    assign mod_dat = pwdata[15:8];
    assign meas_ev = (r_reg.st == S_MEAS) & ev[6];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = pins;
        r_next.sync2 = r_reg.sync1;
        r_next.sync3 = r_reg.sync2[6:0];
        r_next.pready = 1'b0;
        if (r_reg.gap != 26'h0) begin
            r_next.gap = r_reg.gap - 26'h1;
        end
        // Zero wait states: data is registered in the setup cycle
        if (psel && !penable) begin
            r_next.pready = 1'b1;
            r_next.pslverr = 1'b0;
            unique case (paddr)
                `OFF_CTRL: r_next.prdata = {25'h0, r_reg.stop, r_reg.unlock, 1'b0,
                                            r_reg.ext_src, r_reg.mode_sel};
                `OFF_STATUS: r_next.prdata = {23'h0, r_reg.refused, r_reg.halted,
                                              r_reg.st, r_reg.mode_run, r_reg.ready};
                `OFF_TADDR: r_next.prdata = {21'h0, r_reg.taddr};
                `OFF_CHAR: r_next.prdata = {8'h0, r_reg.display, r_reg.new_data,
                                            8'(r_reg.char_sel)};
                default: begin
                    r_next.prdata = 32'h0;
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (wr && paddr == `OFF_CTRL) begin
            r_next.mode_sel = mode_t'(pwdata[2:0]);
            r_next.ext_src = pwdata[`CTRL_EXT];
            r_next.unlock = pwdata[`CTRL_UNLOCK];
            r_next.stop = pwdata[`CTRL_STOP];
        end
        if (wr && paddr == `OFF_TADDR && pwdata[10:0] < LIB) begin
            r_next.taddr = pwdata[10:0]; // [R17]
        end
        if (wr && paddr == `OFF_CHAR) begin
            r_next.char_sel = mod_idx;
            r_next.new_data = mod_dat;
        end
        if (mod_ev) begin
            r_next.prog[mod_idx] = mod_dat; // [R14]
        end
        unique case (r_reg.st)
            S_IDLE: begin
                if (start) begin
                    // Mode latched here; later selector moves are ignored  [R21]
                    r_next.mode_run = r_next.mode_sel;
                    r_next.halted = 1'b0;
                    r_next.refused = 1'b0;
                    r_next.retried = 1'b0;
                    r_next.cnt = '0;
                    r_next.disc_addr = r_reg.taddr;
                    r_next.disc_seek = 1'b0;
                    unique case (r_next.mode_sel)
                        M_EXAMINE: r_next.st = S_IDLE;
                        M_REG_DISC: begin
                            if (r_next.unlock) begin // [R15]
                                r_next.st = S_WRITE;
                                r_next.disc_seek = 1'b1;
                            end else begin
                                r_next.refused = 1'b1;
                            end
                        end
                        M_TAPE_DISC: begin
                            if (r_next.unlock) begin // [R15]
                                r_next.st = S_LOAD; // [R16]
                            end else begin
                                r_next.refused = 1'b1;
                            end
                        end
                        M_TAPE_SEQ: r_next.st = S_LOAD; // [R11]
                        default: begin
                            r_next.st = S_LOAD;
                            r_next.disc_seek = ~r_reg.ext_src;
                        end
                    endcase
                end
            end
            S_LOAD: begin
                if (in_ev) begin
                    // Characters shift in from the top, first lands in cell 0  [R2]
                    r_next.prog = {in_char, r_reg.prog[NCHAR-1:1]};
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (r_reg.cnt == LASTC) begin
                        r_next.cnt = '0;
                        r_next.disc_seek = 1'b0;
                        unique case (r_reg.mode_run)
                            M_DISC_TAPE: r_next.st = S_PUNCH; // [R3]
                            M_TAPE_DISC: begin
                                r_next.st = S_WRITE; // [R16]
                                r_next.disc_seek = 1'b1;
                            end
                            default: begin
                                r_next.st = S_MEAS; // [R6]
                                r_next.meas_req = 1'b1;
                                if (from_tape) begin
                                    r_next.gap = GAP_LD; // [R19]
                                end
                            end
                        endcase
                    end
                end
            end
            S_PUNCH, S_WRITE: begin
                if (!r_reg.pend) begin
                    r_next.out_data = r_reg.prog[0];
                    r_next.pend = 1'b1;
                    if (r_reg.st == S_PUNCH) begin
                        r_next.punch_tgl = ~r_reg.punch_tgl; // [R3]
                    end else begin
                        r_next.wr_tgl = ~r_reg.wr_tgl; // [R15]
                    end
                end else if (ev[4]) begin
                    // Rotate, not shift, so the word survives the transfer
                    r_next.pend = 1'b0;
                    r_next.prog = {r_reg.prog[0], r_reg.prog[NCHAR-1:1]};
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (r_reg.cnt == LASTC) begin
                        r_next.cnt = '0;
                        if (r_reg.st == S_PUNCH) begin
                            r_next.st = S_PDONE;
                        end else begin
                            r_next.st = S_IDLE;
                            r_next.unlock = 1'b0; // [R15]
                            r_next.disc_seek = 1'b0;
                        end
                    end
                end
            end
            S_PDONE: begin
                if (ev[5]) begin
                    r_next.st = S_IDLE; // [R4]
                end
            end
            S_MEAS: begin
                if (ev[6]) begin
                    r_next.meas_req = 1'b0;
                    unique case (r_reg.mode_run)
                        M_LOCATE: begin
                            // Park the disc on the following program  [R5]
                            r_next.taddr = (r_reg.taddr == LIB - 11'h1) ? 11'h000
                                         : r_reg.taddr + 11'h1;
                            r_next.disc_addr = r_next.taddr;
                            r_next.disc_seek = 1'b1;
                            r_next.st = S_IDLE;
                        end
                        M_DISC_SEQ, M_TAPE_SEQ: begin
                            if (oob && act[`ACT_REPEAT] && !r_reg.retried) begin
                                r_next.retried = 1'b1; // [R10]
                                if (from_tape) begin
                                    r_next.st = S_GAP;
                                end else begin
                                    r_next.meas_req = 1'b1;
                                end
                            end else begin
                                r_next.retried = 1'b0;
                                if (halt_hit) begin
                                    r_next.st = S_IDLE; // [R8] [R12]
                                    r_next.halted = 1'b1;
                                end else if (from_tape) begin
                                    r_next.st = stop_req ? S_IDLE : S_GAP; // [R11]
                                end else if (br_hit) begin
                                    r_next.st = S_LOAD; // [R8]
                                    r_next.disc_addr = br_a;
                                    r_next.disc_seek = ~r_reg.ext_src;
                                end else if (act[`ACT_LAST]) begin
                                    r_next.st = S_IDLE;
                                end else begin
                                    r_next.st = S_LOAD; // [R7]
                                    r_next.disc_addr = next_a;
                                    r_next.disc_seek = ~r_reg.ext_src;
                                end
                            end
                        end
                        default: r_next.st = S_IDLE; // [R6]
                    endcase
                end
            end
            S_GAP: begin
                // Disc path has no pacing, only the tape path waits  [R18]
                if (r_reg.gap == 26'h0) begin // [R19]
                    if (r_reg.retried) begin
                        r_next.st = S_MEAS;
                        r_next.meas_req = 1'b1;
                        r_next.gap = GAP_LD;
                    end else begin
                        r_next.st = S_LOAD;
                    end
                end
            end
            default: r_next.st = S_IDLE;
        endcase
        r_next.ready = (r_next.st == S_IDLE); // [R22]
        r_next.disc_read = (r_next.st == S_LOAD) && !from_tape && !r_reg.ext_src;
        r_next.display = (r_next.mode_sel == M_EXAMINE)
                       ? r_next.prog[r_next.char_sel] : 8'h00; // [R13]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign ready = r_reg.ready;
    assign disc_seek = r_reg.disc_seek;
    assign disc_read = r_reg.disc_read;
    assign disc_addr = r_reg.disc_addr;
    assign meas_req = r_reg.meas_req;
    assign punch_tgl = r_reg.punch_tgl;
    assign disc_wr_tgl = r_reg.wr_tgl;
    assign out_data = r_reg.out_data;
    assign char_display = r_reg.display;
    assign prog_word = r_reg.prog;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start_ready;
        start && r_next.mode_sel != M_EXAMINE && r_next.mode_sel != M_REG_DISC
            && r_next.mode_sel != M_TAPE_DISC |=> !r_reg.ready;
    endproperty
    a_start_ready: assert property (p_start_ready) else $error("ready after start"); // [R22]

    property p_mode_hold;
        r_reg.st != S_IDLE ##1 r_reg.st != S_IDLE |-> $stable(r_reg.mode_run);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run"); // [R21]

    property p_fill_punch;
        r_reg.st == S_LOAD && in_ev && r_reg.cnt == LASTC && r_reg.mode_run == M_DISC_TAPE
            |=> r_reg.st == S_PUNCH ##1 r_reg.punch_tgl != $past(r_reg.punch_tgl);
    endproperty
    a_fill_punch: assert property (p_fill_punch) else $error("no punch after fill"); // [R3]

    property p_punch_ready;
        r_reg.st == S_PDONE && ev[5] |=> r_reg.ready;
    endproperty
    a_punch_ready: assert property (p_punch_ready) else $error("not ready after punch"); // [R4]

    property p_single_done;
        meas_ev && r_reg.mode_run == M_DISC_SINGLE |=> r_reg.ready && !r_reg.meas_req;
    endproperty
    a_single_done: assert property (p_single_done) else $error("single not ended"); // [R6]

    property p_seq_reload;
        meas_ev && r_reg.mode_run == M_DISC_SEQ && !oob && !act[`ACT_LAST]
            |=> r_reg.st == S_LOAD && r_reg.disc_addr == $past(next_a);
    endproperty
    a_seq_reload: assert property (p_seq_reload) else $error("no reload"); // [R7]

    property p_halt_hi;
        meas_ev && r_reg.mode_run == M_DISC_SEQ && hi && act[`ACT_HALT_HI]
            && (!act[`ACT_REPEAT] || r_reg.retried) |=> r_reg.halted && r_reg.ready;
    endproperty
    a_halt_hi: assert property (p_halt_hi) else $error("no halt above limit"); // [R9]

    property p_interlock;
        $changed(r_reg.wr_tgl) |-> r_reg.unlock;
    endproperty
    a_interlock: assert property (p_interlock) else $error("write while locked"); // [R15]

    property p_addr;
        r_reg.disc_addr < LIB;
    endproperty
    a_addr: assert property (p_addr) else $error("disc address out of library"); // [R17]

    property p_gap;
        r_reg.st == S_GAP && r_reg.gap != 26'h0 |=> r_reg.st == S_GAP;
    endproperty
    a_gap: assert property (p_gap) else $error("tape pacing skipped"); // [R19]

    property p_modify;
        mod_ev |=> r_reg.prog[$past(mod_idx)] == $past(mod_dat);
    endproperty
    a_modify: assert property (p_modify) else $error("modify lost"); // [R14]

    c_punch: cover property (r_reg.st == S_PDONE && ev[5]);
    c_branch: cover property (meas_ev && r_reg.mode_run == M_DISC_SEQ && br_hit);
    c_gap: cover property (r_reg.st == S_GAP ##1 r_reg.st == S_LOAD);
    c_modify: cover property (mod_ev);
endmodule // measurement_program_controller

// ==== far_side_model.sv ====
// Far-side model: disc store, tape reader, punch and disc writer, measurement unit
`timescale 1ns/1ps
module far_side_model #(
    parameter int NCHAR = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ready,
    input wire logic disc_read,
    input wire logic [10:0] disc_addr,
    input wire logic meas_req,
    input wire logic punch_tgl,
    input wire logic disc_wr_tgl,
    output logic disc_tgl,
    output logic [7:0] disc_data,
    output logic tape_tgl,
    output logic [7:0] tape_data,
    output logic out_ack_tgl,
    output logic punch_done_tgl,
    output logic meas_done_tgl,
    output int meas_cnt,
    output int out_cnt
);
    int ph, idx, ack_w, done_w, meas_w, pcnt;
    logic armed, busy, is_punch, punch_q, wr_q;
    assign tape_data = 8'h5A ^ 8'(pcnt);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {disc_tgl, tape_tgl, out_ack_tgl, punch_done_tgl, meas_done_tgl} <= '0;
            {armed, busy, is_punch, punch_q, wr_q} <= '0;
            disc_data <= 8'h00;
            {ph, idx, ack_w, done_w, meas_w, pcnt, meas_cnt, out_cnt} <= '0;
        end else begin
            ph <= (ph + 1) % 8;
            // Released bus keeps changing so a stale char never looks valid
            if (!disc_read) begin
                disc_data <= ~disc_data;
                idx <= 0;
                armed <= 1'b0;
            end else if (ph == 0) begin
                disc_data <= {disc_addr[3:0], idx[3:0]};
                armed <= 1'b1;
            end else if (ph == 2 && armed) begin
                disc_tgl <= ~disc_tgl;
                idx <= idx + 1;
                armed <= 1'b0;
            end
            if (!ready && !disc_read && ph == 2) begin
                tape_tgl <= ~tape_tgl;
            end
            if (punch_tgl != punch_q || disc_wr_tgl != wr_q) begin
                punch_q <= punch_tgl;
                wr_q <= disc_wr_tgl;
                is_punch <= (punch_tgl != punch_q);
                ack_w <= 6;
                out_cnt <= out_cnt + 1;
            end else if (ack_w > 0) begin
                ack_w <= ack_w - 1;
                if (ack_w == 1) begin
                    out_ack_tgl <= ~out_ack_tgl;
                    pcnt <= is_punch ? (pcnt + 1) % NCHAR : pcnt;
                    done_w <= (is_punch && pcnt == NCHAR - 1) ? 10 : 0;
                end
            end
            if (done_w > 0) begin
                done_w <= done_w - 1;
                punch_done_tgl <= punch_done_tgl ^ (done_w == 1);
            end
            if (!meas_req) begin
                busy <= 1'b0;
            end else if (!busy) begin
                busy <= 1'b1;
                meas_w <= 10;
                meas_cnt <= meas_cnt + 1;
            end
            if (meas_w > 0) begin
                meas_w <= meas_w - 1;
                meas_done_tgl <= meas_done_tgl ^ (meas_w == 1);
            end
        end
    end
endmodule // far_side_model

// ==== tb.sv ====
// Self-checking testbench of the measurement program controller
`timescale 1ns/1ps
`include "mpc_defines.svh"
module tb;
    localparam int NCHAR = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic start_ext = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ready, disc_seek, disc_read, meas_req, punch_tgl, disc_wr_tgl;
    logic disc_tgl, tape_tgl, out_ack_tgl, punch_done_tgl, meas_done_tgl;
    logic [10:0] disc_addr;
    logic [7:0] out_data, char_display, disc_data, tape_data;
    logic [NCHAR*8-1:0] prog_word;
    int meas_cnt, out_cnt, n0;
    int miscompares = 0;
    int samples_checked = 0;
    always #2.5 pclk = ~pclk;
    measurement_program_controller #(.NCHAR(NCHAR), .TAPE_GAP(20)) i_measurement_program_controller (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .start_ext, .disc_tgl, .disc_data, .tape_tgl, .tape_data, .ext_tgl(1'b0),
        .ext_data(8'h00), .out_ack_tgl, .punch_done_tgl, .meas_done_tgl, .limit_hi(1'b0),
        .limit_lo(1'b0), .stop_in(1'b0), .ready, .disc_seek, .disc_read, .disc_addr,
        .meas_req, .punch_tgl, .disc_wr_tgl, .out_data, .char_display, .prog_word);
    far_side_model #(.NCHAR(NCHAR)) i_far_side_model (
        .pclk, .presetn, .ready, .disc_read, .disc_addr, .meas_req, .punch_tgl, .disc_wr_tgl,
        .disc_tgl, .disc_data, .tape_tgl, .tape_data, .out_ack_tgl, .punch_done_tgl,
        .meas_done_tgl, .meas_cnt, .out_cnt);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // --------------------------------------------------------
    // APB master: holds the request until pready is sampled
    // --------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // Start through the register, confirm busy, then wait for the end
    task automatic run(input logic [31:0] c);
        apb(1'b1, `OFF_CTRL, c | 32'h10);
        repeat (3) @(posedge pclk);
        chk(ready, 1'b0);
        wait_ready();
        chk(ready, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(ready, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, `OFF_TADDR, 32'd1600);
        apb(1'b0, `OFF_TADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `OFF_TADDR, 32'd5);
        $display("test reset and registers done");
        run(32'h2);
        chk(prog_word[7:0], 8'h50);
        chk(prog_word[NCHAR*8-1 -: 8], 8'h5F);
        chk(meas_cnt, 1);
        $display("test single disc done");
        apb(1'b1, `OFF_CTRL, 32'h5);
        apb(1'b1, `OFF_CHAR, 32'h2);
        apb(1'b0, `OFF_CHAR, 32'h0);
        chk(rd[23:16], 8'h52);
        chk(char_display, 8'h52);
        apb(1'b1, `OFF_CHAR, 32'h1C302);
        @(posedge pclk);
        chk(prog_word[23:16], 8'hC3);
        $display("test examine modify done");
        run(32'h1);
        chk({disc_seek, disc_addr}, {1'b1, 11'd6});
        $display("test locate done");
        apb(1'b1, `OFF_CTRL, 32'h0);
        n0 = out_cnt;
        start_ext <= 1'b1;
        repeat (6) @(posedge pclk);
        start_ext <= 1'b0;
        chk(ready, 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h5);
        wait_ready();
        chk(out_cnt - n0, NCHAR);
        chk(ready, 1'b1);
        $display("test disc to tape done");
        n0 = out_cnt;
        apb(1'b1, `OFF_CTRL, 32'h16);
        repeat (3) @(posedge pclk);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk({rd[8], rd[0]}, 2'b11);
        run(32'h26);
        chk(out_cnt - n0, NCHAR);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk(rd[5], 1'b0);
        run(32'h27);
        chk(prog_word[7:0], 8'h5A);
        chk(out_cnt - n0, 2 * NCHAR);
        $display("test disc write done");
        report_and_stop();
    end
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule // tb
